/* File: rtl/lssbs_defines.svh */
// Constants for the LED source select and boot strap pin logic.
// Assumes the includer uses these macros with the lssbs_pkg types.
//
// What this block does
// - First WAN LED source comes from WAN control bits 2 to 0.
// - Second WAN LED source comes from WAN control bits 6 to 4.
// - Each LAN port first LED uses switch control 0 bits 27 to 25.
// - Each LAN port second LED uses switch control 0 bits 24 to 22.
// - Codes 0-6: speed, link, duplex, coll, activity, fd coll, link/act.
// - During reset the WAN LED pins are read as the boot width strap.
// - Width strap 01 byte, 10 half-word, 11 word; 00 reserved.
// - Captured width applies to boot bank 0.
// - During reset the RTS pin is read as CPU clock select; 0 is PLL.
// - Outside reset the RTS pin is driven as the active-low UART output.
// - During reset every pin output is released to high impedance.
`ifndef LSSBS_DEFINES_SVH
`define LSSBS_DEFINES_SVH

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define LSSBS_WAN_A_HI 2
`define LSSBS_WAN_A_LO 0
`define LSSBS_WAN_B_HI 6
`define LSSBS_WAN_B_LO 4
`define LSSBS_LAN_A_HI 27
`define LSSBS_LAN_A_LO 25
`define LSSBS_LAN_B_HI 24
`define LSSBS_LAN_B_LO 22

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define LSSBS_WIDTH_RST 2'h3
`define LSSBS_CLKSEL_RST 1'h0
`define LSSBS_RESET_MIN_CYCLES 256

`endif

/* File: rtl/lssbs_pkg.sv */
// Types for the LED source select and boot strap pin logic.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package lssbs_pkg;

  // ----------------------------------------------------------------------
  // LED source select codes
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    LSSBS_SEL_SPEED = 3'h0,
    LSSBS_SEL_LINK = 3'h1,
    LSSBS_SEL_DUPLEX = 3'h2,
    LSSBS_SEL_COLL = 3'h3,
    LSSBS_SEL_ACT = 3'h4,
    LSSBS_SEL_FDCOLL = 3'h5,
    LSSBS_SEL_LINKACT = 3'h6,
    LSSBS_SEL_NONE = 3'h7
  } lssbs_sel_t;

  // Boot bank width strap codes.
  typedef enum logic [1:0] {
    LSSBS_W_RSVD = 2'h0,
    LSSBS_W_BYTE = 2'h1,
    LSSBS_W_HALF = 2'h2,
    LSSBS_W_WORD = 2'h3
  } lssbs_width_t;

  // Pin mode state, one-hot.
  typedef enum logic [1:0] {
    LSSBS_ST_RESET = 2'b01,
    LSSBS_ST_RUN = 2'b10
  } lssbs_state_t;

endpackage : lssbs_pkg

`default_nettype wire

/* File: rtl/lssbs_top.sv */
// LED source select multiplexer and reset-time strap capture.
// Assumes all inputs synchronous to clock; pins resolved by the bench.
`include "lssbs_defines.svh"
`default_nettype none

module lssbs_top #(
  parameter int LAN_PORTS = 4
) (
  input wire logic clock,
  input wire logic chip_reset_n,
  input wire logic [31:0] wan_misc_ctrl,
  input wire logic [31:0] switch_ctrl0,
  // Per-port status inputs, one vector each: speed, link, full duplex,
  // collision, activity. Index 0 is WAN, 1..LAN_PORTS are LAN.
  input wire logic [LAN_PORTS:0] st_speed,
  input wire logic [LAN_PORTS:0] st_link,
  input wire logic [LAN_PORTS:0] st_duplex,
  input wire logic [LAN_PORTS:0] st_coll,
  input wire logic [LAN_PORTS:0] st_act,
  input wire logic uart_rts_n,
  input wire logic wan_indicator_a_in,
  input wire logic wan_indicator_b_in,
  output logic wan_indicator_a_out,
  output logic wan_indicator_a_oe_n,
  output logic wan_indicator_b_out,
  output logic wan_indicator_b_oe_n,
  output logic [LAN_PORTS-1:0] lan_indicator_a,
  output logic [LAN_PORTS-1:0] lan_indicator_b,
  output logic lan_indicator_oe_n,
  input wire logic uart_request_to_send_n_in,
  output logic uart_request_to_send_n_out,
  output logic uart_request_to_send_n_oe_n,
  output logic [1:0] boot_bank_width_strap,
  output logic [1:0] bank0_width,
  output logic bank0_width_valid,
  output logic core_clock_source_strap,
  output logic core_clock_from_pll
);

  // ----------------------------------------------------------------------
  // LED source decode
  // ----------------------------------------------------------------------
  // LEDs are active high here; the inactive level is 0.
  function automatic logic led_pick(input logic [2:0] sel, input logic sp,
      input logic lk, input logic dx, input logic co, input logic ac);
    logic r;
    r = 1'b0;
    case (lssbs_pkg::lssbs_sel_t'(sel))
      lssbs_pkg::LSSBS_SEL_SPEED: r = sp;
      lssbs_pkg::LSSBS_SEL_LINK: r = lk;
      lssbs_pkg::LSSBS_SEL_DUPLEX: r = dx;
      lssbs_pkg::LSSBS_SEL_COLL: r = co;
      lssbs_pkg::LSSBS_SEL_ACT: r = ac;
      lssbs_pkg::LSSBS_SEL_FDCOLL: r = co & dx;
      lssbs_pkg::LSSBS_SEL_LINKACT: r = lk & ~ac;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : led_pick

  logic [2:0] wan_sel_a;
  logic [2:0] wan_sel_b;
  logic [2:0] lan_sel_a;
  logic [2:0] lan_sel_b;
  assign wan_sel_a = wan_misc_ctrl[`LSSBS_WAN_A_HI:`LSSBS_WAN_A_LO];
  assign wan_sel_b = wan_misc_ctrl[`LSSBS_WAN_B_HI:`LSSBS_WAN_B_LO];
  assign lan_sel_a = switch_ctrl0[`LSSBS_LAN_A_HI:`LSSBS_LAN_A_LO];
  assign lan_sel_b = switch_ctrl0[`LSSBS_LAN_B_HI:`LSSBS_LAN_B_LO];

  // ----------------------------------------------------------------------
  // Mode, straps and LED registers
  // ----------------------------------------------------------------------
  lssbs_pkg::lssbs_state_t state_reg;
  lssbs_pkg::lssbs_state_t state_next;
  logic [1:0] width_reg;
  logic [1:0] width_next;
  logic clksel_reg;
  logic clksel_next;
  logic wan_a_reg;
  logic wan_a_next;
  logic wan_b_reg;
  logic wan_b_next;
  logic [LAN_PORTS-1:0] lan_a_reg;
  logic [LAN_PORTS-1:0] lan_a_next;
  logic [LAN_PORTS-1:0] lan_b_reg;
  logic [LAN_PORTS-1:0] lan_b_next;
  logic rts_reg;
  logic rts_next;

  always_comb begin
    state_next = state_reg;
    width_next = width_reg;
    clksel_next = clksel_reg;
    case (state_reg)
      lssbs_pkg::LSSBS_ST_RESET: begin
        // First cycle with reset released: straps still hold pin levels.
        state_next = lssbs_pkg::LSSBS_ST_RUN;
        width_next = {wan_indicator_b_in, wan_indicator_a_in};
        clksel_next = uart_request_to_send_n_in;
      end
      lssbs_pkg::LSSBS_ST_RUN: state_next = lssbs_pkg::LSSBS_ST_RUN;
      default: state_next = lssbs_pkg::LSSBS_ST_RESET;
    endcase
    wan_a_next = led_pick(wan_sel_a, st_speed[0], st_link[0], st_duplex[0],
        st_coll[0], st_act[0]);
    wan_b_next = led_pick(wan_sel_b, st_speed[0], st_link[0], st_duplex[0],
        st_coll[0], st_act[0]);
    for (int i = 0; i < LAN_PORTS; i++) begin
      lan_a_next[i] = led_pick(lan_sel_a, st_speed[i+1], st_link[i+1],
          st_duplex[i+1], st_coll[i+1], st_act[i+1]);
      lan_b_next[i] = led_pick(lan_sel_b, st_speed[i+1], st_link[i+1],
          st_duplex[i+1], st_coll[i+1], st_act[i+1]);
    end
    rts_next = uart_rts_n;
  end

  always_ff @(posedge clock) begin
    if (!chip_reset_n) begin
      state_reg <= lssbs_pkg::LSSBS_ST_RESET;
      wan_a_reg <= 1'b0;
      wan_b_reg <= 1'b0;
      lan_a_reg <= '0;
      lan_b_reg <= '0;
      rts_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      wan_a_reg <= wan_a_next;
      wan_b_reg <= wan_b_next;
      lan_a_reg <= lan_a_next;
      lan_b_reg <= lan_b_next;
      rts_reg <= rts_next;
    end
  end

  // Straps are not cleared by reset; they are only overwritten at release.
  always_ff @(posedge clock) begin
    if (!chip_reset_n) begin
      width_reg <= width_reg;
      clksel_reg <= clksel_reg;
    end else begin
      width_reg <= width_next;
      clksel_reg <= clksel_next;
    end
  end

  // ----------------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------------
  logic run;
  assign run = (state_reg == lssbs_pkg::LSSBS_ST_RUN);

  assign wan_indicator_a_out = wan_a_reg;
  assign wan_indicator_b_out = wan_b_reg;
  assign lan_indicator_a = lan_a_reg;
  assign lan_indicator_b = lan_b_reg;
  assign uart_request_to_send_n_out = rts_reg;
  // Pins float while reset is held and until straps are taken.
  assign wan_indicator_a_oe_n = ~run;
  assign wan_indicator_b_oe_n = ~run;
  assign lan_indicator_oe_n = ~run;
  assign uart_request_to_send_n_oe_n = ~run;

  assign boot_bank_width_strap = width_reg;
  assign bank0_width = width_reg;
  assign bank0_width_valid = run & (width_reg != 2'h0);
  assign core_clock_source_strap = clksel_reg;
  assign core_clock_from_pll = run & ~clksel_reg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  strap_capture_a: assert property (@(posedge clock)
      disable iff (!chip_reset_n)
      $rose(run) |-> width_reg == {$past(wan_indicator_b_in),
      $past(wan_indicator_a_in)} && clksel_reg ==
      $past(uart_request_to_send_n_in))
    else $error("strap not captured at reset release");
  strap_hold_a: assert property (@(posedge clock)
      disable iff (!chip_reset_n)
      run && $past(run) |-> $stable(width_reg) && $stable(clksel_reg))
    else $error("strap changed outside reset");
  pins_float_a: assert property (@(posedge clock)
      !chip_reset_n |=> wan_indicator_a_oe_n && wan_indicator_b_oe_n &&
      lan_indicator_oe_n && uart_request_to_send_n_oe_n)
    else $error("pin driven during reset");
  leds_dark_a: assert property (@(posedge clock)
      !chip_reset_n |=> !wan_indicator_a_out && !wan_indicator_b_out &&
      lan_indicator_a == '0 && lan_indicator_b == '0)
    else $error("led lit during reset");
  width_valid_a: assert property (@(posedge clock)
      disable iff (!chip_reset_n)
      $rose(run) |-> bank0_width_valid == ({$past(wan_indicator_b_in),
      $past(wan_indicator_a_in)} != 2'h0))
    else $error("width valid flag wrong");
  sel_none_a: assert property (@(posedge clock)
      disable iff (!chip_reset_n)
      wan_sel_a == 3'h7 |=> !wan_indicator_a_out)
    else $error("code 111 lit wan led");
  lan_none_b_a: assert property (@(posedge clock)
      disable iff (!chip_reset_n)
      lan_sel_b == 3'h7 |=> lan_indicator_b == '0)
    else $error("code 111 lit lan led");
  wan_link_a: assert property (@(posedge clock)
      disable iff (!chip_reset_n)
      wan_sel_a == 3'h1 |=> wan_indicator_a_out == $past(st_link[0]))
    else $error("wan led a not link");
  wan_act_b_a: assert property (@(posedge clock)
      disable iff (!chip_reset_n)
      wan_sel_b == 3'h4 |=> wan_indicator_b_out == $past(st_act[0]))
    else $error("wan led b not activity");
  lan_speed_a: assert property (@(posedge clock)
      disable iff (!chip_reset_n)
      lan_sel_a == 3'h0 |=> lan_indicator_a[0] == $past(st_speed[1]))
    else $error("lan led a not speed");
  lan_fdcoll_a: assert property (@(posedge clock)
      disable iff (!chip_reset_n)
      lan_sel_a == 3'h5 |=> lan_indicator_a[0] ==
      ($past(st_coll[1]) && $past(st_duplex[1])))
    else $error("lan led a not fd collision");
  lan_dup_b_a: assert property (@(posedge clock)
      disable iff (!chip_reset_n)
      lan_sel_b == 3'h2 |=> lan_indicator_b[LAN_PORTS-1] ==
      $past(st_duplex[LAN_PORTS]))
    else $error("lan led b not duplex");
  rts_drive_a: assert property (@(posedge clock)
      disable iff (!chip_reset_n)
      run |-> !uart_request_to_send_n_oe_n ##1
      uart_request_to_send_n_out == $past(uart_rts_n))
    else $error("rts not driven in run");
  pll_sel_a: assert property (@(posedge clock)
      disable iff (!chip_reset_n)
      $rose(run) |-> core_clock_from_pll == !$past(uart_request_to_send_n_in))
    else $error("pll select not taken from strap");

endmodule : lssbs_top

`default_nettype wire

/* File: tb/lssbs_board_model.sv */
// Board model: boot strap resistors on the shared LED and RTS pins.
// Assumes the bench supplies strap levels and the design's pin drivers.
`default_nettype none

module lssbs_board_model (
  input wire logic [1:0] width_strap,
  input wire logic clock_strap,
  input wire logic wan_a_out,
  input wire logic wan_a_oe_n,
  input wire logic wan_b_out,
  input wire logic wan_b_oe_n,
  input wire logic rts_out,
  input wire logic rts_oe_n,
  output logic wan_a_pin,
  output logic wan_b_pin,
  output logic rts_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // A released pin settles to the level of its strap resistor.
  assign wan_a_pin = wan_a_oe_n ? width_strap[0] : wan_a_out;
  assign wan_b_pin = wan_b_oe_n ? width_strap[1] : wan_b_out;
  assign rts_pin = rts_oe_n ? clock_strap : rts_out;
endmodule : lssbs_board_model

`default_nettype wire

/* File: tb/tb_led_source_select_and_boot_straps.sv */
// Testbench for the LED source select and boot strap pin logic.
// Assumes lssbs_top and the board model are compiled before it.
`default_nettype none

module tb_led_source_select_and_boot_straps;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock, chip_reset_n, uart_rts_n, clock_strap;
  logic [31:0] wan_misc_ctrl, switch_ctrl0;
  logic [4:0] st_speed, st_link, st_duplex, st_coll, st_act;
  logic wan_a_pin, wan_b_pin, rts_pin, wa_out, wa_oe_n, wb_out, wb_oe_n;
  logic [3:0] lan_a, lan_b;
  logic lan_oe_n, rts_out, rts_oe_n, valid, clk_strap_q, from_pll;
  logic [1:0] width_strap, strap_q, bank_w;
  int n_fail, total_checks, cycles;
  // Expected LED per select code for the fixed status pattern below.
  logic [4:0] exp_tab [8] = '{5'h16, 5'h1a, 5'h0d, 5'h1c, 5'h0b, 5'h0c,
                              5'h10, 5'h00};

  lssbs_top #(.LAN_PORTS(4)) DUT (.clock(clock), .chip_reset_n(chip_reset_n),
    .wan_misc_ctrl(wan_misc_ctrl), .switch_ctrl0(switch_ctrl0),
    .st_speed(st_speed), .st_link(st_link), .st_duplex(st_duplex),
    .st_coll(st_coll), .st_act(st_act), .uart_rts_n(uart_rts_n),
    .wan_indicator_a_in(wan_a_pin), .wan_indicator_b_in(wan_b_pin),
    .wan_indicator_a_out(wa_out), .wan_indicator_a_oe_n(wa_oe_n),
    .wan_indicator_b_out(wb_out), .wan_indicator_b_oe_n(wb_oe_n),
    .lan_indicator_a(lan_a), .lan_indicator_b(lan_b),
    .lan_indicator_oe_n(lan_oe_n), .uart_request_to_send_n_in(rts_pin),
    .uart_request_to_send_n_out(rts_out),
    .uart_request_to_send_n_oe_n(rts_oe_n),
    .boot_bank_width_strap(strap_q), .bank0_width(bank_w),
    .bank0_width_valid(valid), .core_clock_source_strap(clk_strap_q),
    .core_clock_from_pll(from_pll));

  lssbs_board_model board (.width_strap(width_strap),
    .clock_strap(clock_strap), .wan_a_out(wa_out), .wan_a_oe_n(wa_oe_n),
    .wan_b_out(wb_out), .wan_b_oe_n(wb_oe_n), .rts_out(rts_out),
    .rts_oe_n(rts_oe_n), .wan_a_pin(wan_a_pin), .wan_b_pin(wan_b_pin),
    .rts_pin(rts_pin));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test

  // Resets with the given straps {clock select, width} and checks capture.
  task strap_reset(input int hold, input logic [2:0] s);
    @(posedge clock);
    chip_reset_n <= 1'b0;
    {clock_strap, width_strap} <= s;
    repeat (hold) @(posedge clock);
    #1;
    chk({12'h000, wa_oe_n, wb_oe_n, lan_oe_n, rts_oe_n}, 16'h000f);
    @(posedge clock);
    chip_reset_n <= 1'b1;
    @(posedge clock);
    #1;
    chk({12'h000, bank_w, strap_q}, {12'h000, s[1:0], s[1:0]});
    chk({12'h000, valid, clk_strap_q, from_pll, rts_oe_n},
        {12'h000, s[1:0] != 2'h0, s[2], !s[2], 1'b0});
    @(posedge clock);
    {clock_strap, width_strap} <= ~s;
    repeat (3) @(posedge clock);
    #1;
    chk({11'h000, bank_w, strap_q, clk_strap_q},
        {11'h000, s[1:0], s[1:0], s[2]});
  endtask : strap_reset

  always @(posedge clock) begin
    cycles++;
    if (cycles >= 5000) begin
      n_fail++;
      stop_test;
    end
  end

  initial begin
    chip_reset_n = 1'b0;
    uart_rts_n = 1'b1;
    wan_misc_ctrl = 32'h0000_0000;
    switch_ctrl0 = 32'h0000_0000;
    {st_speed, st_link, st_duplex} = {5'h16, 5'h1a, 5'h0d};
    {st_coll, st_act} = {5'h1c, 5'h0b};
    strap_reset(10, 3'h3);
    for (int c = 0; c < 8; c++) begin
      @(posedge clock);
      wan_misc_ctrl <= {25'h1ff_ffff, ~c[2:0], 1'b1, c[2:0]};
      switch_ctrl0 <= {4'hf, c[2:0], ~c[2:0], 22'h3f_ffff};
      uart_rts_n <= c[0];
      repeat (2) @(posedge clock);
      #1;
      chk({11'h000, lan_a, wa_out},
          {11'h000, exp_tab[c]});
      chk({11'h000, lan_b, wb_out},
          {11'h000, exp_tab[7-c]});
      chk({15'h0000, rts_out}, {15'h0000, c[0]});
    end
    for (int s = 0; s < 8; s++) strap_reset(256, s[2:0]);
    stop_test;
  end
endmodule : tb_led_source_select_and_boot_straps

`default_nettype wire
